// >>> common/radio_pkt_params.svh
// Constants of the radio packet handler: encodings, reset values and fixed bytes.
// Operation
// - Fixed or variable format; payload within FIFO depth.
// - Fixed length counts address plus message, min one.
// - Variable length byte excludes itself, min two bytes.
// - Transmit adds preamble, sync, CRC, then coding.
// - Start on first write or on threshold.
// - Standby loading; start checked entering transmit.
// - Filler preamble; finish filler byte before frame.
// - Receive strips preamble, sync, decodes, filters payload.
// - Packet-received event; CRC-pass event and result.
// - Failed CRC flushes and restarts unless disabled.
// - Stop writing after frame; restart when FIFO empty (handler: hunts again only after receive is left and re-entered).
// - Received payload readable in standby when enabled.
// - Sync match always on; mismatch dropped silently.
// - Sync detect starts payload and raises event.
// - Address codes 01, 10, 11 accept node/broadcast.
// - Address filter receive only; address stays in FIFO.
// - Variable length byte below maximum kept, else dropped.
// - CRC appended on transmit, checked and stripped on receive.
// - CCITT checksum catching leading and trailing zeros.
// - Whitening with 9-bit LFSR x^9+x^5+1.
// - Manchester 10/01 on payload and CRC only.
`ifndef RADIO_PKT_PARAMS_SVH
`define RADIO_PKT_PARAMS_SVH
`define PREAMBLE_BYTE 8'hAA
`define CRC_POLY      16'h1021
`define CRC_INIT      16'hFFFF
`define LFSR_INIT     9'h1FF
`define BCAST_ZERO    8'h00
`define BCAST_ONES    8'hFF
`define DEPTH_16      7'h10
`define DEPTH_32      7'h20
`define DEPTH_48      7'h30
`define DEPTH_64      7'h40
`define FILT_OFF      2'h0
`define FILT_ZERO     2'h2
`define FILT_BOTH     2'h3
`endif

// >>> common/radio_pkt_pkg.sv
// Types shared by the radio packet handler.
package radio_pkt_pkg;
  // Operating mode driven by the chip mode controller.
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'h0,
    MODE_STBY  = 2'h1,
    MODE_RX    = 2'h2,
    MODE_TX    = 2'h3
  } mode_t;
  // Transmit sequencer states, Gray coded along the frame.
  typedef enum logic [2:0] {
    TX_FILL = 3'h0,
    TX_PRE  = 3'h1,
    TX_SYNC = 3'h3,
    TX_PAY  = 3'h2,
    TX_CRC  = 3'h6,
    TX_DONE = 3'h7
  } tx_state_t;
  // Receive sequencer states, Gray coded along the frame.
  typedef enum logic [1:0] {
    RX_HUNT = 2'h0,
    RX_PAY  = 2'h1,
    RX_CRC  = 2'h3,
    RX_HOLD = 2'h2
  } rx_state_t;
endpackage : radio_pkt_pkg

// >>> dv/host_model.sv
// Host side model that loads and drains the data buffer.
`timescale 1ns/1ps
module host_model (
  input  wire logic       core_clk,
  input  wire logic       wr_ready,
  input  wire logic       rd_valid,
  input  wire logic [7:0] rd_data,
  output logic            wr_valid,
  output logic [7:0]      wr_data,
  output logic            rd_req
);
  initial begin wr_valid = 0; wr_data = 8'h00; rd_req = 0; end
  // Loads one payload byte and holds it until taken; the line is scrambled afterwards.
  task automatic put(input logic [7:0] v);
    wr_valid <= 1; wr_data <= v;
    do @(posedge core_clk); while (wr_ready !== 1'b1);
    wr_valid <= 0; wr_data <= ~v;
    @(posedge core_clk);
  endtask : put
  // Reads one byte and waits a bounded time for the answer.
  task automatic get(output logic [7:0] v);
    rd_req <= 1;
    @(posedge core_clk);
    rd_req <= 0;
    for (int i = 0; i < 8 && rd_valid !== 1'b1; i++) @(posedge core_clk);
    v = rd_data;
  endtask : get
endmodule : host_model

// >>> dv/radio_pkt_monitor.sv
// Port checker of the packet handler.
`timescale 1ns/1ps
module radio_pkt_monitor (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic                 chip_stb,
  input wire logic                 fifo_stby_access,
  input wire logic                 crc_on,
  input wire logic                 rd_req,
  input wire logic                 rd_valid,
  input wire logic                 wr_ready,
  input wire logic                 fifo_empty,
  input wire logic                 fifo_full,
  input wire logic                 tx_chip,
  input wire logic                 tx_done,
  input wire logic                 sync_det,
  input wire logic                 crc_ok,
  input wire logic                 payload_ready,
  input wire radio_pkt_pkg::mode_t mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A host read that the handler has to take.
  sequence s_rd_take;
    rd_req && !fifo_empty && (mode == radio_pkt_pkg::MODE_RX
      || (mode == radio_pkt_pkg::MODE_STBY && fifo_stby_access));
  endsequence
  property p_rd_ans; s_rd_take |=> rd_valid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_cause; rd_valid |-> $past(rd_req) && !$past(fifo_empty); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read data unasked");
  property p_full; fifo_full |-> !wr_ready && !fifo_empty; endproperty
  a_full: assert property (p_full) else $error("full buffer accepts");
  property p_wr_mode; wr_ready |-> mode == radio_pkt_pkg::MODE_TX
    || (mode == radio_pkt_pkg::MODE_STBY && fifo_stby_access); endproperty
  a_wr_mode: assert property (p_wr_mode) else $error("write open in wrong mode");
  property p_crc_pair; crc_ok |-> payload_ready && crc_on; endproperty
  a_crc_pair: assert property (p_crc_pair) else $error("check event alone");
  property p_done; tx_done |-> $past(mode) == radio_pkt_pkg::MODE_TX; endproperty
  a_done: assert property (p_done) else $error("done outside transmit");
  property p_chip; mode == radio_pkt_pkg::MODE_TX && $past(mode) == radio_pkt_pkg::MODE_TX
    && !$past(chip_stb) |-> $stable(tx_chip); endproperty
  a_chip: assert property (p_chip) else $error("chip moved without strobe");
  property p_evt_rx; sync_det || payload_ready |-> $past(mode) == radio_pkt_pkg::MODE_RX;
  endproperty
  a_evt_rx: assert property (p_evt_rx) else $error("receive event outside receive");
endmodule : radio_pkt_monitor
bind radio_packet_handler radio_pkt_monitor radio_pkt_monitor_i (.*);

// >>> dv/testbench.sv
// Self-checking bench of the packet handler.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst_n = 0, chip_stb = 0, rx_chip = 0, fmt_variable = 0, crc_on = 1;
  logic crc_autoclr = 1, manchester_on = 0, whitening_on = 0, fifo_stby_access = 1;
  logic tx_start_sel = 1, wr_valid, rd_req, wr_ready, rd_valid, fifo_empty, fifo_full;
  logic tx_chip, tx_done, sync_det, payload_ready, crc_ok, crc_status;
  logic [1:0] fifo_size_sel = 2'h0, sync_size = 2'h1, sync_tol = 2'h0, adrs_filt = 2'h1;
  logic [1:0] div = 2'h0;
  logic [5:0] fifo_thresh = 6'h01;
  logic [7:0] payload_len = 8'h02, preamble_size = 8'h01, node_adrs = 8'h00;
  logic [7:0] wr_data, rd_data, a, b, v;
  logic [15:0] c;
  logic [31:0] sync_value = 32'h0000_0000, seed = 32'h0000_5836, w = 32'h0000_0000;
  radio_pkt_pkg::mode_t mode = radio_pkt_pkg::MODE_STBY;
  int errors = 0, checks_done = 0, prdy = 0, sdet = 0, k;
  radio_packet_handler radio_packet_handler_i (.*);
  host_model host_model_i (.*);
  initial forever #2.5 core_clk = ~core_clk;
  // One chip strobe every fourth cycle; counts received-frame and sync events.
  always @(posedge core_clk) begin
    chip_stb <= &div;
    div <= div + 2'h1;
    if (payload_ready === 1'b1) prdy++;
    if (sync_det === 1'b1) sdet++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction : xs
  // Checksum over a two-byte payload, preset all ones, MSB first.
  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] r = 16'hFFFF;
    for (int i = 15; i >= 0; i--) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction : crc16
  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end
  endtask : chk
  task automatic stb; do @(posedge core_clk); while (chip_stb !== 1'b1); endtask : stb
  task automatic getc; stb(); @(posedge core_clk); w = {w[30:0], tx_chip}; endtask : getc
  task automatic send(input logic [7:0] x);
    for (int i = 7; i >= 0; i--) begin rx_chip <= x[i]; stb(); end
  endtask : send
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin #400_000; errors++; end_of_test(); end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    seed = xs(seed);
    a = {seed[7:1], 1'b0};
    b = seed[15:8];
    c = crc16({a, b});
    sync_value <= {seed[23:16] | 8'hC3, seed[31:24], 16'h0000};
    @(posedge core_clk);
    chk("empty", 1, fifo_empty);
    mode <= radio_pkt_pkg::MODE_TX;
    host_model_i.put(a);
    host_model_i.put(b);
    for (k = 0; k < 300 && w[15:0] !== sync_value[31:16]; k++) getc();
    chk("preamble", 8'hAA, w[23:16]);
    repeat (32) getc();
    chk("tx payload", {a, b}, w[31:16]);
    chk("tx crc", c, w[15:0]);
    for (k = 0; k < 200 && tx_done !== 1'b1; k++) @(posedge core_clk);
    chk("tx done", 1, tx_done);
    mode <= radio_pkt_pkg::MODE_RX;
    node_adrs <= a;
    for (int f = 0; f < 2; f++) begin
      send(8'hAA); send(sync_value[31:24]); send(sync_value[23:16]); send(f ? a : 8'h55);
      if (f) begin send(b); send(c[15:8]); send(c[7:0]); end
    end
    for (k = 0; k < 200 && crc_ok !== 1'b1; k++) @(posedge core_clk);
    chk("crc ok", 1, crc_ok);
    @(posedge core_clk);
    chk("frames", 1, prdy);
    chk("syncs", 2, sdet);
    chk("crc status", 1, crc_status);
    mode <= radio_pkt_pkg::MODE_STBY;
    host_model_i.get(v);
    chk("rx addr", a, v);
    host_model_i.get(v);
    chk("rx msg", b, v);
    chk("stripped", 1, fifo_empty);
    end_of_test();
  end
endmodule : testbench

// >>> rtl/radio_packet_handler.sv
// Packet handler between the data FIFO and the chip-level modulator and demodulator.
`timescale 1ns/1ps
`include "radio_pkt_params.svh"
module radio_packet_handler (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire radio_pkt_pkg::mode_t mode,
  input  wire logic                 chip_stb,
  input  wire logic                 fmt_variable,
  input  wire logic [1:0]           fifo_size_sel,
  input  wire logic [5:0]           fifo_thresh,
  input  wire logic [7:0]           payload_len,
  input  wire logic [7:0]           preamble_size,
  input  wire logic [1:0]           sync_size,
  input  wire logic [1:0]           sync_tol,
  input  wire logic [31:0]          sync_value,
  input  wire logic [7:0]           node_adrs,
  input  wire logic [1:0]           adrs_filt,
  input  wire logic                 crc_on,
  input  wire logic                 crc_autoclr,
  input  wire logic                 manchester_on,
  input  wire logic                 whitening_on,
  input  wire logic                 fifo_stby_access,
  input  wire logic                 tx_start_sel,
  input  wire logic                 wr_valid,
  input  wire logic [7:0]           wr_data,
  output logic                      wr_ready,
  input  wire logic                 rd_req,
  output logic [7:0]                rd_data,
  output logic                      rd_valid,
  output logic                      fifo_empty,
  output logic                      fifo_full,
  output logic                      tx_chip,
  output logic                      tx_done,
  input  wire logic                 rx_chip,
  output logic                      sync_det,
  output logic                      payload_ready,
  output logic                      crc_ok,
  output logic                      crc_status
);

  // Advances the CCITT checksum by one byte, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_byte

  // FIFO storage and occupancy.
  logic [7:0]  mem [64];      // Ring of the largest depth; occupancy limits use.
  logic [5:0]  wr_ptr_r;      // Next slot to write.
  logic [5:0]  rd_ptr_r;      // Next slot to read.
  logic [6:0]  fifo_cnt_r;    // Bytes held.
  logic [6:0]  depth;         // Selected depth in bytes.
  logic [7:0]  fifo_out;      // Byte at the read pointer.
  logic [7:0]  rx_byte;       // Completed receive byte, stored by the receiver.
  logic        host_wr;       // Host write accepted.
  logic        host_rd;       // Host read accepted.
  logic        tx_pop;        // Transmitter takes a byte.
  logic        rx_wr;         // Receiver stores a byte.
  logic        rx_flush;      // Receiver discards the FIFO.
  logic        in_tx;         // Transmit mode.
  logic        in_rx;         // Receive mode.
  logic        in_stby;       // Standby mode.

  assign in_tx    = (mode == radio_pkt_pkg::MODE_TX);
  assign in_rx    = (mode == radio_pkt_pkg::MODE_RX);
  assign in_stby  = (mode == radio_pkt_pkg::MODE_STBY);
  assign fifo_out = mem[rd_ptr_r];

  // Depth follows the size select, capping every received payload.
  always_comb begin
    unique case (fifo_size_sel)
      2'h0: depth = `DEPTH_16;
      2'h1: depth = `DEPTH_32;
      2'h2: depth = `DEPTH_48;
      2'h3: depth = `DEPTH_64;
    endcase
  end

  assign fifo_empty = (fifo_cnt_r == 7'h00);
  assign fifo_full  = (fifo_cnt_r >= depth);
  // Host loads in transmit, or in standby when that access is enabled.
  assign wr_ready   = (in_tx | (in_stby & fifo_stby_access)) & ~fifo_full;
  assign host_wr    = wr_valid & wr_ready;
  // Host drains in receive, or in standby when that access is enabled.
  assign host_rd    = rd_req & ~fifo_empty & (in_rx | (in_stby & fifo_stby_access));

  // Storage array is written without reset; its contents follow the pointers.
  always_ff @(posedge core_clk) begin
    if (host_wr) begin
      mem[wr_ptr_r] <= wr_data;
    end else if (rx_wr) begin
      mem[wr_ptr_r] <= rx_byte;
    end
  end

  // Pointers and count; a flush empties the FIFO at once.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r   <= 6'h00;
      rd_ptr_r   <= 6'h00;
      fifo_cnt_r <= 7'h00;
    end else if (rx_flush) begin
      wr_ptr_r   <= 6'h00;
      rd_ptr_r   <= 6'h00;
      fifo_cnt_r <= 7'h00;
    end else begin
      if (host_wr | rx_wr) begin
        wr_ptr_r <= wr_ptr_r + 6'h01;
      end
      if (host_rd | tx_pop) begin
        rd_ptr_r <= rd_ptr_r + 6'h01;
      end
      fifo_cnt_r <= fifo_cnt_r + 7'((host_wr | rx_wr)) - 7'((host_rd | tx_pop));
    end
  end

  // Read data is registered one cycle after the request.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= host_rd;
      if (host_rd) begin
        rd_data <= fifo_out;
      end
    end
  end

  // Transmit side.
  radio_pkt_pkg::tx_state_t tx_st_r, tx_st_nxt; // Sequencer state.
  logic [7:0]  tx_sh_r;       // Byte being shifted out.
  logic [2:0]  tx_bit_r;      // Bit index in the byte.
  logic        tx_half_r;     // Second Manchester chip pending.
  logic        tx_coded_r;    // Current byte is payload or checksum.
  logic [7:0]  tx_cnt_r, tx_cnt_nxt; // Bytes left or bytes sent.
  logic [7:0]  tx_total_r;    // Payload bytes in this frame.
  logic [31:0] tx_syn_r;      // Sync bytes still to send, top first.
  logic [15:0] tx_crc_r;      // Running checksum.
  logic [8:0]  tx_lfsr_r;     // Whitening sequence.
  logic [7:0]  tx_byte_nxt;   // Next byte to load.
  logic        tx_coded_nxt;  // Next byte is coded.
  logic        tx_data_bit;   // Current bit after whitening.
  logic        tx_man;        // Current byte uses Manchester.
  logic        tx_bit_end;    // Last chip of a bit goes out.
  logic        tx_byte_end;   // Last chip of a byte goes out.
  logic        start_ok;      // Frame start condition met.

  assign tx_data_bit = tx_sh_r[7] ^ (tx_coded_r & whitening_on & tx_lfsr_r[0]);
  assign tx_man      = tx_coded_r & manchester_on;
  assign tx_bit_end  = chip_stb & (~tx_man | tx_half_r);
  assign tx_byte_end = tx_bit_end & (tx_bit_r == 3'h7);
  // First write or threshold reached, checked at the end of each filler byte ahead of the frame in transmit.
  assign start_ok = tx_start_sel ? ~fifo_empty : (fifo_cnt_r >= {1'b0, fifo_thresh});

  // Chooses the next byte at each byte boundary of the frame.
  always_comb begin
    tx_st_nxt    = tx_st_r;
    tx_cnt_nxt   = tx_cnt_r;
    tx_byte_nxt  = `PREAMBLE_BYTE;
    tx_coded_nxt = 1'b0;
    tx_pop       = 1'b0;
    if (in_tx && tx_byte_end) begin
      unique case (tx_st_r)
        radio_pkt_pkg::TX_FILL: begin
          // The filler byte has finished before the frame begins.
          if (start_ok && (preamble_size != 8'h00)) begin
            tx_st_nxt  = radio_pkt_pkg::TX_PRE;
            tx_cnt_nxt = preamble_size;
          end else if (start_ok) begin
            tx_st_nxt   = radio_pkt_pkg::TX_SYNC;
            tx_cnt_nxt  = {6'h00, sync_size};
            tx_byte_nxt = sync_value[31:24];
          end
        end
        radio_pkt_pkg::TX_PRE: begin
          if (tx_cnt_r > 8'h01) begin
            tx_cnt_nxt = tx_cnt_r - 8'h01;
          end else begin
            tx_st_nxt   = radio_pkt_pkg::TX_SYNC;
            tx_cnt_nxt  = {6'h00, sync_size};
            tx_byte_nxt = sync_value[31:24];
          end
        end
        radio_pkt_pkg::TX_SYNC: begin
          if (tx_cnt_r != 8'h00) begin
            tx_cnt_nxt  = tx_cnt_r - 8'h01;
            tx_byte_nxt = tx_syn_r[31:24];
          end else begin
            tx_st_nxt    = radio_pkt_pkg::TX_PAY;
            tx_cnt_nxt   = 8'h01;
            tx_byte_nxt  = fifo_out;
            tx_coded_nxt = 1'b1;
            tx_pop       = 1'b1;
          end
        end
        radio_pkt_pkg::TX_PAY: begin
          if (tx_cnt_r < tx_total_r) begin
            tx_cnt_nxt   = tx_cnt_r + 8'h01;
            tx_byte_nxt  = fifo_out;
            tx_coded_nxt = 1'b1;
            tx_pop       = 1'b1;
          end else if (crc_on) begin
            tx_st_nxt    = radio_pkt_pkg::TX_CRC;
            tx_cnt_nxt   = 8'h00;
            tx_byte_nxt  = tx_crc_r[15:8];
            tx_coded_nxt = 1'b1;
          end else begin
            tx_st_nxt = radio_pkt_pkg::TX_DONE;
          end
        end
        radio_pkt_pkg::TX_CRC: begin
          if (tx_cnt_r == 8'h00) begin
            tx_cnt_nxt   = 8'h01;
            tx_byte_nxt  = tx_crc_r[7:0];
            tx_coded_nxt = 1'b1;
          end else begin
            tx_st_nxt = radio_pkt_pkg::TX_DONE;
          end
        end
        radio_pkt_pkg::TX_DONE: begin
          // Filler continues until the mode controller leaves transmit.
          tx_st_nxt = radio_pkt_pkg::TX_DONE;
        end
      endcase
    end
  end

  // Sequencer state, counters and frame bookkeeping.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r    <= radio_pkt_pkg::TX_FILL;
      tx_cnt_r   <= 8'h00;
      tx_total_r <= 8'h00;
      tx_syn_r   <= 32'h0000_0000;
      tx_crc_r   <= `CRC_INIT;
    end else if (!in_tx) begin
      tx_st_r  <= radio_pkt_pkg::TX_FILL;
      tx_cnt_r <= 8'h00;
    end else begin
      tx_st_r  <= tx_st_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      if (tx_byte_end && tx_st_nxt == radio_pkt_pkg::TX_SYNC && tx_st_r != tx_st_nxt) begin
        tx_syn_r <= {sync_value[23:0], 8'h00};
      end else if (tx_byte_end && tx_st_r == radio_pkt_pkg::TX_SYNC) begin
        tx_syn_r <= {tx_syn_r[23:0], 8'h00};
      end
      if (tx_pop && tx_st_r == radio_pkt_pkg::TX_SYNC) begin
        // Length byte carries the bytes that follow it.
        tx_total_r <= fmt_variable ? (fifo_out + 8'h01) : payload_len;
        tx_crc_r   <= crc_byte(`CRC_INIT, fifo_out);
      end else if (tx_pop) begin
        tx_crc_r <= crc_byte(tx_crc_r, fifo_out);
      end
    end
  end

  // Serializer with Manchester chips and whitening sequence.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r    <= `PREAMBLE_BYTE;
      tx_bit_r   <= 3'h0;
      tx_half_r  <= 1'b0;
      tx_coded_r <= 1'b0;
      tx_lfsr_r  <= `LFSR_INIT;
      tx_chip    <= 1'b0;
    end else if (!in_tx) begin
      tx_sh_r    <= `PREAMBLE_BYTE;
      tx_bit_r   <= 3'h0;
      tx_half_r  <= 1'b0;
      tx_coded_r <= 1'b0;
    end else begin
      if (chip_stb) begin
        // One is sent as chips 10, zero as 01.
        tx_chip <= (tx_man & tx_half_r) ? ~tx_data_bit : tx_data_bit;
      end
      if (tx_byte_end) begin
        tx_sh_r    <= tx_byte_nxt;
        tx_bit_r   <= 3'h0;
        tx_half_r  <= 1'b0;
        tx_coded_r <= tx_coded_nxt;
      end else if (tx_bit_end) begin
        tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
        tx_bit_r  <= tx_bit_r + 3'h1;
        tx_half_r <= 1'b0;
      end else if (chip_stb) begin
        tx_half_r <= 1'b1;
      end
      if (tx_pop && tx_st_r == radio_pkt_pkg::TX_SYNC) begin
        tx_lfsr_r <= `LFSR_INIT;
      end else if (tx_bit_end && tx_coded_r) begin
        tx_lfsr_r <= {tx_lfsr_r[0] ^ tx_lfsr_r[5], tx_lfsr_r[8:1]};
      end
    end
  end

  assign tx_done = (tx_st_r == radio_pkt_pkg::TX_DONE);

  // Receive side.
  radio_pkt_pkg::rx_state_t rx_st_r; // Sequencer state.
  logic [31:0] rx_win_r;      // Last raw chips for sync search.
  logic [31:0] win_nxt;       // Window including the current chip.
  logic [31:0] sync_mask;     // Bits of the window that are compared.
  logic [31:0] sync_exp;      // Expected sync pattern, low aligned.
  logic [5:0]  sync_err;      // Mismatching chips.
  logic        sync_hit;      // Sync accepted this cycle.
  logic [7:0]  rx_sh_r;       // Bits gathered so far.
  logic [2:0]  rx_bit_r;      // Bit index in the byte.
  logic        rx_half_r;     // First Manchester chip captured.
  logic        rx_first_r;    // Value of that first chip.
  logic [7:0]  rx_idx_r;      // Bytes of the section received.
  logic [7:0]  rx_total_r;    // Payload bytes expected.
  logic [7:0]  rx_crc_hi_r;   // Received checksum high byte.
  logic [15:0] rx_crc_r;      // Running checksum.
  logic [8:0]  rx_lfsr_r;     // De-whitening sequence.
  logic        rx_bit_ok;     // A decoded bit is ready.
  logic        rx_d;          // Decoded, de-whitened bit.
  logic        rx_byte_ok;    // A whole byte is ready.
  logic        adrs_ok;       // Address byte passes the filter.
  logic        len_ok;        // Length byte passes the limit.
  logic        is_adrs;       // Current byte is the address.
  logic        rx_last;       // Current byte ends the payload.
  logic        rx_drop;       // Frame is discarded.
  logic        crc_pass;      // Checksums agree.

  assign win_nxt   = {rx_win_r[30:0], rx_chip};
  assign sync_mask = 32'hFFFF_FFFF >> {2'h3 - sync_size, 3'h0};
  assign sync_exp  = sync_value >> {2'h3 - sync_size, 3'h0};

  // Counts chip errors over the configured sync length.
  always_comb begin
    sync_err = 6'h00;
    for (int i = 0; i < 32; i++) begin
      sync_err = sync_err + 6'((win_nxt[i] ^ sync_exp[i]) & sync_mask[i]);
    end
  end

  // Hunting only starts once the previous payload has been drained.
  assign sync_hit = in_rx & chip_stb & fifo_empty & (rx_st_r == radio_pkt_pkg::RX_HUNT)
                  & (sync_err <= {4'h0, sync_tol});

  // Bit recovery: 10 decodes as one, then the whitening bit is removed.
  assign rx_bit_ok  = chip_stb & (~manchester_on | rx_half_r);
  assign rx_d       = (manchester_on ? rx_first_r : rx_chip)
                    ^ (whitening_on & rx_lfsr_r[0]);
  assign rx_byte_ok = in_rx & rx_bit_ok & (rx_bit_r == 3'h7)
                    & (rx_st_r == radio_pkt_pkg::RX_PAY || rx_st_r == radio_pkt_pkg::RX_CRC);
  assign rx_byte    = {rx_sh_r[6:0], rx_d};

  assign is_adrs  = (rx_idx_r == {7'h00, fmt_variable}) & (adrs_filt != `FILT_OFF);
  assign adrs_ok  = (rx_byte == node_adrs)
                  | (adrs_filt[1] & (rx_byte == `BCAST_ZERO))
                  | ((adrs_filt == `FILT_BOTH) & (rx_byte == `BCAST_ONES));
  assign len_ok   = (rx_byte < payload_len);
  assign rx_last  = ((rx_idx_r == 8'h00 && fmt_variable) ? (rx_byte + 8'h01) : rx_total_r)
                  == (rx_idx_r + 8'h01);
  assign crc_pass = ({rx_crc_hi_r, rx_byte} == rx_crc_r);

  // Drop decisions for the payload byte; dropped frames raise no packet-received event.
  always_comb begin
    rx_drop = 1'b0;
    if (rx_byte_ok && rx_st_r == radio_pkt_pkg::RX_PAY) begin
      if (rx_idx_r == 8'h00 && fmt_variable && !len_ok) begin
        rx_drop = 1'b1;
      end else if (is_adrs && !adrs_ok) begin
        rx_drop = 1'b1;
      end else if (fifo_full) begin
        rx_drop = 1'b1;
      end
    end
  end

  // Only payload bytes reach the FIFO, length and address included.
  assign rx_wr    = rx_byte_ok & (rx_st_r == radio_pkt_pkg::RX_PAY) & ~rx_drop;
  assign rx_flush = rx_drop | (rx_byte_ok & (rx_st_r == radio_pkt_pkg::RX_CRC)
                  & (rx_idx_r != 8'h00) & ~crc_pass & crc_autoclr);

  // Receive sequencer and events.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r       <= radio_pkt_pkg::RX_HUNT;
      rx_idx_r      <= 8'h00;
      rx_total_r    <= 8'h00;
      rx_crc_hi_r   <= 8'h00;
      rx_crc_r      <= `CRC_INIT;
      sync_det      <= 1'b0;
      payload_ready <= 1'b0;
      crc_ok        <= 1'b0;
      crc_status    <= 1'b0;
    end else begin
      sync_det      <= sync_hit;
      payload_ready <= 1'b0;
      crc_ok        <= 1'b0;
      if (!in_rx) begin
        rx_st_r <= radio_pkt_pkg::RX_HUNT;
      end else if (sync_hit) begin
        rx_st_r    <= radio_pkt_pkg::RX_PAY;
        rx_idx_r   <= 8'h00;
        rx_total_r <= payload_len;
        rx_crc_r   <= `CRC_INIT;
      end else if (rx_drop) begin
        rx_st_r <= radio_pkt_pkg::RX_HUNT;
      end else if (rx_wr) begin
        rx_crc_r <= crc_byte(rx_crc_r, rx_byte);
        rx_idx_r <= rx_idx_r + 8'h01;
        if (rx_idx_r == 8'h00 && fmt_variable) begin
          rx_total_r <= rx_byte + 8'h01;
        end
        if (rx_last && crc_on) begin
          rx_st_r  <= radio_pkt_pkg::RX_CRC;
          rx_idx_r <= 8'h00;
        end else if (rx_last) begin
          rx_st_r       <= radio_pkt_pkg::RX_HOLD;
          payload_ready <= 1'b1;
        end
      end else if (rx_byte_ok && rx_idx_r == 8'h00) begin
        rx_crc_hi_r <= rx_byte;
        rx_idx_r    <= 8'h01;
      end else if (rx_byte_ok) begin
        // Checksum bytes are compared and never stored.
        crc_status <= crc_pass;
        if (crc_pass || !crc_autoclr) begin
          rx_st_r       <= radio_pkt_pkg::RX_HOLD;
          payload_ready <= 1'b1;
          crc_ok        <= crc_pass;
        end else begin
          rx_st_r <= radio_pkt_pkg::RX_HUNT;
        end
      end
    end
  end

  // Chip window, bit assembly and de-whitening sequence.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_win_r   <= 32'h0000_0000;
      rx_sh_r    <= 8'h00;
      rx_bit_r   <= 3'h0;
      rx_half_r  <= 1'b0;
      rx_first_r <= 1'b0;
      rx_lfsr_r  <= `LFSR_INIT;
    end else if (sync_hit || !in_rx) begin
      rx_win_r  <= 32'h0000_0000;
      rx_bit_r  <= 3'h0;
      rx_half_r <= 1'b0;
      rx_lfsr_r <= `LFSR_INIT;
    end else begin
      if (chip_stb && rx_st_r == radio_pkt_pkg::RX_HUNT) begin
        rx_win_r <= win_nxt;
      end
      if (chip_stb && manchester_on && !rx_half_r) begin
        rx_half_r  <= 1'b1;
        rx_first_r <= rx_chip;
      end else if (rx_bit_ok) begin
        rx_half_r <= 1'b0;
        rx_sh_r   <= rx_byte;
        rx_bit_r  <= rx_bit_r + 3'h1;
        rx_lfsr_r <= {rx_lfsr_r[0] ^ rx_lfsr_r[5], rx_lfsr_r[8:1]};
      end
    end
  end

endmodule : radio_packet_handler
